// *** alarm_pin_defines.vh ***
/*
  Constants for the alarm pin and interrupt mask block: register offsets,
  reset values, field positions and widths.
  Assumes it is included by bare name in each design file that needs it.
*/
`ifndef ALARM_PIN_DEFINES_VH
`define ALARM_PIN_DEFINES_VH

// register offsets on the register access port
`define ADDR_ALARM_PIN_ENABLES 8'h14
`define ADDR_SELECT_PIN_CONFIG 8'h15
`define ADDR_ALARM_PIN_POLARITY 8'h16
`define ADDR_SIGNAL_LOSS_MASKS 8'h17

// reset values, reserved bits included
`define RST_ALARM_PIN_ENABLES 8'h3e
`define RST_SELECT_PIN_CONFIG 8'hff
`define RST_ALARM_PIN_POLARITY 8'hdf
`define RST_SIGNAL_LOSS_MASKS 8'h1f

// alarm_pin_enables fields
`define BIT_IRQ_PIN_ENABLE 0
`define BIT_LOCK_LOSS_PIN_ENABLE 1
`define BIT_CLK1_FAULT_PIN_ENABLE 2
`define BIT_CLK2_FAULT_PIN_ENABLE 3
`define ENABLES_RW_MSB 3

// select_pin_config fields
`define BIT_SELECT_PIN_CONTROL 0
`define BIT_CLK1_ACTIVE_PIN_ENABLE 1
`define SELECT_RW_MSB 1

// alarm_pin_polarity fields
`define BIT_IRQ_POLARITY 0
`define BIT_LOCK_LOSS_POLARITY 1
`define BIT_FAULT_PIN_POLARITY 2
`define BIT_ACTIVE_PIN_POLARITY 3
`define POLARITY_RW_MSB 3

// signal_loss_masks fields
`define BIT_REF_SIGLOSS_MASK 0
`define BIT_CLK1_SIGLOSS_MASK 1
`define BIT_CLK2_SIGLOSS_MASK 2
`define SIGLOSS_RW_MSB 2

// frequency offset and lock masks arriving from the next register
`define BIT_LOCK_LOSS_MASK 0
`define BIT_CLK1_FREQ_OFFSET_MASK 1
`define BIT_CLK2_FREQ_OFFSET_MASK 2

// alarm flag vector layout
`define NUM_ALARM_FLAGS 6

// manual clock choice encodings
`define SEL_INPUT_CLOCK_1 2'h0
`define SEL_INPUT_CLOCK_2 2'h1

`define RDATA_UNMAPPED 8'h00

`endif

// *** level_sync.v ***
/*
  Two flip-flop synchroniser for a single level from a pin.
  Assumes the input may change at any time relative to ref_clk.
*/
`timescale 1ns/10ps

module level_sync
(
  input wire ref_clk,
  input wire rstn,
  input wire async_in,
  output reg sync_out
);

  reg meta_r;

  // meta_r is read by sync_out only, never by other logic
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** pin_driver.v ***
/*
  Registered driver for one tristatable status pin: applies the active
  polarity and the enable.
  Assumes the pad resolves the level from pin_o and the low-active enable.
*/
`timescale 1ns/10ps

module pin_driver
(
  input wire ref_clk,
  input wire rstn,
  input wire status,
  input wire enable,
  input wire active_high,
  output reg pin_o,
  output reg pin_oe_n
);

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pin_o <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else
    begin
      // active low polarity inverts the status before it reaches the pad
      pin_o <= active_high ? status : ~status;
      pin_oe_n <= ~enable;
    end
  end

endmodule

// *** alarm_pin_and_interrupt_mask.v ***
/*
  Alarm pin routing and interrupt masking: four control registers decide
  which internal alarm statuses appear on the tristatable alarm pins, with
  what polarity, how the select/active pin is used, and which alarm flags
  feed the combined interrupt.
  Assumes the alarm flags, statuses, next-register masks and clock select
  bits come from logic on ref_clk; only the select/active pin is
  asynchronous. The serial access port drives the register port here.
*/
// Functional notes
// - clk2 fault pin enable 0 tristates that pin, 1 drives clk2 fault.
// - with interrupt pin enable 0, clk1 fault pin enable 0 tristates its output, 1 shows clk1 fault.
// - lock-loss pin enable 0 tristates lock pin, 1 drives lock-loss status.
// - interrupt pin enable 1 drives shared pin with combined interrupt.
// - both interrupt and clk1 fault enables 0 tristate the shared pin.
// - interrupt off but clk1 fault on: shared pin reports clk1 fault.
// - active pin enable drives clk1 active unless pin selects the clock.
// - in manual mode, control bit picks pin level or register select bits.
// - active polarity bit sets active low or high for active pin.
// - fault polarity bit sets level sense of both clock fault pins.
// - lock-loss polarity bit sets level sense of lock-loss pin.
// - interrupt polarity bit sets level sense of interrupt on shared pin.
// - clk2 signal-loss mask 0 lets its flag raise the interrupt.
// - clk1 signal-loss mask 0 lets its flag raise the interrupt.
// - reference signal-loss mask 0 lets its flag raise the interrupt.
// - writing a signal-loss mask never alters the sticky flag itself.
// - frequency-offset and lock flags are masked the same way.
`timescale 1ns/10ps
`include "alarm_pin_defines.vh"

module alarm_pin_and_interrupt_mask
(
  input wire ref_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  input wire clk1_fault_status,
  input wire clk2_fault_status,
  input wire lock_loss_irq_status,
  input wire clk1_active_status,
  input wire ref_sigloss_flag,
  input wire clk1_sigloss_flag,
  input wire clk2_sigloss_flag,
  input wire lock_loss_flag,
  input wire clk1_freq_offset_flag,
  input wire clk2_freq_offset_flag,
  input wire [2:0] freq_lock_masks,
  input wire auto_select_mode,
  input wire [1:0] clock_select_bits,
  input wire select_or_active_pin_in,
  output wire select_or_active_pin_out,
  output wire select_or_active_pin_oe_n,
  output wire clk2_fault_out,
  output wire clk2_fault_out_oe_n,
  output wire irq_or_clk1_fault_out,
  output wire irq_or_clk1_fault_out_oe_n,
  output wire lock_loss_out,
  output wire lock_loss_out_oe_n,
  output reg irq_status,
  output reg [1:0] active_clock_select
);

  // writable fields only; reserved bits are never stored
  reg [`ENABLES_RW_MSB:0] enables_r;
  reg [`SELECT_RW_MSB:0] select_cfg_r;
  reg [`POLARITY_RW_MSB:0] polarity_r;
  reg [`SIGLOSS_RW_MSB:0] sigloss_mask_r;

  wire [7:0] rst_enables;
  wire [7:0] rst_select;
  wire [7:0] rst_polarity;
  wire [7:0] rst_sigloss;
  wire [7:0] enables_view;
  wire [7:0] select_view;
  wire [7:0] polarity_view;
  wire [7:0] sigloss_view;
  reg [7:0] rdata_nxt;
  reg hit_nxt;

  wire [`NUM_ALARM_FLAGS-1:0] alarm_flags;
  wire [`NUM_ALARM_FLAGS-1:0] alarm_masks;
  wire [`NUM_ALARM_FLAGS-1:0] unmasked_flags;
  wire irq_nxt;

  wire pin_level_sync;
  wire pin_selects_clock;
  reg [1:0] clock_select_nxt;

  reg shared_status;
  reg shared_enable;
  reg shared_active_high;

  // register field aliases
  wire irq_pin_enable;
  wire lock_loss_pin_enable;
  wire clk1_fault_pin_enable;
  wire clk2_fault_pin_enable;
  wire select_pin_control;
  wire clk1_active_pin_enable;
  wire irq_polarity;
  wire lock_loss_polarity;
  wire fault_pin_polarity;
  wire active_pin_polarity;

  assign rst_enables = `RST_ALARM_PIN_ENABLES;
  assign rst_select = `RST_SELECT_PIN_CONFIG;
  assign rst_polarity = `RST_ALARM_PIN_POLARITY;
  assign rst_sigloss = `RST_SIGNAL_LOSS_MASKS;

  assign irq_pin_enable = enables_r[`BIT_IRQ_PIN_ENABLE];
  assign lock_loss_pin_enable = enables_r[`BIT_LOCK_LOSS_PIN_ENABLE];
  assign clk1_fault_pin_enable = enables_r[`BIT_CLK1_FAULT_PIN_ENABLE];
  assign clk2_fault_pin_enable = enables_r[`BIT_CLK2_FAULT_PIN_ENABLE];
  assign select_pin_control = select_cfg_r[`BIT_SELECT_PIN_CONTROL];
  assign clk1_active_pin_enable =
    select_cfg_r[`BIT_CLK1_ACTIVE_PIN_ENABLE];
  assign irq_polarity = polarity_r[`BIT_IRQ_POLARITY];
  assign lock_loss_polarity = polarity_r[`BIT_LOCK_LOSS_POLARITY];
  assign fault_pin_polarity = polarity_r[`BIT_FAULT_PIN_POLARITY];
  assign active_pin_polarity = polarity_r[`BIT_ACTIVE_PIN_POLARITY];

  // register writes
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      enables_r <= rst_enables[`ENABLES_RW_MSB:0];
      select_cfg_r <= rst_select[`SELECT_RW_MSB:0];
      polarity_r <= rst_polarity[`POLARITY_RW_MSB:0];
      sigloss_mask_r <= rst_sigloss[`SIGLOSS_RW_MSB:0];
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_ALARM_PIN_ENABLES:
        begin
          enables_r <= reg_wdata[`ENABLES_RW_MSB:0];
        end
        `ADDR_SELECT_PIN_CONFIG:
        begin
          select_cfg_r <= reg_wdata[`SELECT_RW_MSB:0];
        end
        `ADDR_ALARM_PIN_POLARITY:
        begin
          polarity_r <= reg_wdata[`POLARITY_RW_MSB:0];
        end
        `ADDR_SIGNAL_LOSS_MASKS:
        begin
          // the flags live in the monitors; only the mask is stored here
          sigloss_mask_r <= reg_wdata[`SIGLOSS_RW_MSB:0];
        end
        default:
        begin
          enables_r <= enables_r;
        end
      endcase
    end
  end

  // register reads: reserved bits come from the reset constants
  assign enables_view =
    {rst_enables[7:`ENABLES_RW_MSB+1], enables_r};
  assign select_view =
    {rst_select[7:`SELECT_RW_MSB+1], select_cfg_r};
  assign polarity_view =
    {rst_polarity[7:`POLARITY_RW_MSB+1], polarity_r};
  assign sigloss_view =
    {rst_sigloss[7:`SIGLOSS_RW_MSB+1], sigloss_mask_r};

  always @*
  begin
    rdata_nxt = `RDATA_UNMAPPED;
    hit_nxt = 1'b1;
    case (reg_addr)
      `ADDR_ALARM_PIN_ENABLES:
      begin
        rdata_nxt = enables_view;
      end
      `ADDR_SELECT_PIN_CONFIG:
      begin
        rdata_nxt = select_view;
      end
      `ADDR_ALARM_PIN_POLARITY:
      begin
        rdata_nxt = polarity_view;
      end
      `ADDR_SIGNAL_LOSS_MASKS:
      begin
        rdata_nxt = sigloss_view;
      end
      default:
      begin
        hit_nxt = 1'b0;
      end
    endcase
  end

  // read data holds until the next read so a slow serial shifter can use it
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= `RDATA_UNMAPPED;
      reg_hit <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_nxt;
      reg_hit <= hit_nxt;
    end
  end

  // interrupt: sticky flags gated by their masks, then ORed
  assign alarm_flags[`BIT_REF_SIGLOSS_MASK] = ref_sigloss_flag;
  assign alarm_flags[`BIT_CLK1_SIGLOSS_MASK] = clk1_sigloss_flag;
  assign alarm_flags[`BIT_CLK2_SIGLOSS_MASK] = clk2_sigloss_flag;
  assign alarm_flags[`SIGLOSS_RW_MSB+1+`BIT_LOCK_LOSS_MASK] =
    lock_loss_flag;
  assign alarm_flags[`SIGLOSS_RW_MSB+1+`BIT_CLK1_FREQ_OFFSET_MASK] =
    clk1_freq_offset_flag;
  assign alarm_flags[`SIGLOSS_RW_MSB+1+`BIT_CLK2_FREQ_OFFSET_MASK] =
    clk2_freq_offset_flag;

  // signal-loss masks below, lock and offset masks from the next register
  assign alarm_masks = {freq_lock_masks, sigloss_mask_r};

  genvar fi;
  generate
    for (fi = 0; fi < `NUM_ALARM_FLAGS; fi = fi + 1)
    begin : g_mask
      // mask 1 removes the flag from the interrupt only
      assign unmasked_flags[fi] =
        alarm_flags[fi] & ~alarm_masks[fi];
    end
  endgenerate

  assign irq_nxt = |unmasked_flags;

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      irq_status <= 1'b0;
    end
    else
    begin
      irq_status <= irq_nxt;
    end
  end

  // clock selection via the select/active pin
  level_sync u_sel_sync
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(select_or_active_pin_in),
    .sync_out(pin_level_sync)
  );

  // pin control only matters while selection is manual
  assign pin_selects_clock =
    ~auto_select_mode & select_pin_control;

  always @*
  begin
    clock_select_nxt = clock_select_bits;
    if (pin_selects_clock)
    begin
      // low level picks input clock 1, high level input clock 2
      if (pin_level_sync)
      begin
        clock_select_nxt = `SEL_INPUT_CLOCK_2;
      end
      else
      begin
        clock_select_nxt = `SEL_INPUT_CLOCK_1;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      active_clock_select <= `SEL_INPUT_CLOCK_1;
    end
    else
    begin
      active_clock_select <= clock_select_nxt;
    end
  end

  // shared interrupt / clk1 fault pin source
  always @*
  begin
    shared_status = 1'b0;
    shared_enable = 1'b0;
    shared_active_high = 1'b0;
    if (irq_pin_enable)
    begin
      // registered irq keeps the pin glitch free across mask writes
      shared_status = irq_status;
      shared_enable = 1'b1;
      shared_active_high = irq_polarity;
    end
    else if (clk1_fault_pin_enable)
    begin
      shared_status = clk1_fault_status;
      shared_enable = 1'b1;
      shared_active_high = fault_pin_polarity;
    end
  end

  // pin drivers; each adds one register stage
  pin_driver u_shared_pin
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .status(shared_status),
    .enable(shared_enable),
    .active_high(shared_active_high),
    .pin_o(irq_or_clk1_fault_out),
    .pin_oe_n(irq_or_clk1_fault_out_oe_n)
  );

  pin_driver u_clk2_fault_pin
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .status(clk2_fault_status),
    .enable(clk2_fault_pin_enable),
    .active_high(fault_pin_polarity),
    .pin_o(clk2_fault_out),
    .pin_oe_n(clk2_fault_out_oe_n)
  );

  pin_driver u_lock_loss_pin
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .status(lock_loss_irq_status),
    .enable(lock_loss_pin_enable),
    .active_high(lock_loss_polarity),
    .pin_o(lock_loss_out),
    .pin_oe_n(lock_loss_out_oe_n)
  );

  // while the pin chooses the clock it is an input, so never drive it
  pin_driver u_active_pin
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .status(clk1_active_status),
    .enable(clk1_active_pin_enable & ~pin_selects_clock),
    .active_high(active_pin_polarity),
    .pin_o(select_or_active_pin_out),
    .pin_oe_n(select_or_active_pin_oe_n)
  );

endmodule

// *** alarm_pin_props.sv ***
/*
  Checker for the alarm pin block: shadows the control fields from
  register writes and relates pin outputs to them.
  Assumes it is bound to alarm_pin_and_interrupt_mask.
*/
`timescale 1ns/10ps
module alarm_pin_props
(
  input wire ref_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire clk1_fault_status,
  input wire clk2_fault_status,
  input wire lock_loss_irq_status,
  input wire clk1_active_status,
  input wire ref_sigloss_flag,
  input wire clk1_sigloss_flag,
  input wire clk2_sigloss_flag,
  input wire lock_loss_flag,
  input wire clk1_freq_offset_flag,
  input wire clk2_freq_offset_flag,
  input wire [2:0] freq_lock_masks,
  input wire auto_select_mode,
  input wire [1:0] clock_select_bits,
  input wire select_or_active_pin_out,
  input wire select_or_active_pin_oe_n,
  input wire clk2_fault_out,
  input wire clk2_fault_out_oe_n,
  input wire irq_or_clk1_fault_out,
  input wire irq_or_clk1_fault_out_oe_n,
  input wire lock_loss_out,
  input wire lock_loss_out_oe_n,
  input wire irq_status,
  input wire [1:0] active_clock_select
);
  reg [3:0] en_r;
  reg [1:0] sel_r;
  reg [3:0] pol_r;
  reg [2:0] msk_r;
  wire act_drv;
  wire irq_nxt;
  assign act_drv = sel_r[1] & ~(~auto_select_mode & sel_r[0]);
  assign irq_nxt = |({clk2_freq_offset_flag, clk1_freq_offset_flag,
    lock_loss_flag, clk2_sigloss_flag, clk1_sigloss_flag,
    ref_sigloss_flag} & ~{freq_lock_masks, msk_r});
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      en_r <= 4'he;
      sel_r <= 2'h3;
      pol_r <= 4'hf;
      msk_r <= 3'h7;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        8'h14: en_r <= reg_wdata[3:0];
        8'h15: sel_r <= reg_wdata[1:0];
        8'h16: pol_r <= reg_wdata[3:0];
        8'h17: msk_r <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_clk2_pin_drive: assert property (
    $past(rstn) |-> clk2_fault_out_oe_n == !$past(en_r[3]) &&
    (!$past(en_r[3]) ||
    clk2_fault_out == $past(pol_r[2] ~^ clk2_fault_status)))
    else $error("clk2 fault pin wrong");
  chk_lock_pin_drive: assert property (
    $past(rstn) |-> lock_loss_out_oe_n == !$past(en_r[1]) &&
    (!$past(en_r[1]) ||
    lock_loss_out == $past(pol_r[1] ~^ lock_loss_irq_status)))
    else $error("lock loss pin wrong");
  chk_shared_pin_enable: assert property (
    $past(rstn) |->
    irq_or_clk1_fault_out_oe_n == !$past(en_r[0] | en_r[2]))
    else $error("shared pin enable wrong");
  chk_shared_irq_level: assert property (
    $past(rstn) && $past(en_r[0]) |->
    irq_or_clk1_fault_out == $past(pol_r[0] ~^ irq_status))
    else $error("shared pin irq level wrong");
  chk_shared_fault_level: assert property (
    $past(rstn) && $past(!en_r[0] && en_r[2]) |->
    irq_or_clk1_fault_out == $past(pol_r[2] ~^ clk1_fault_status))
    else $error("shared pin fault level wrong");
  chk_irq_mask_or: assert property (
    $past(rstn) |-> irq_status == $past(irq_nxt))
    else $error("combined interrupt wrong");
  chk_active_pin_enable: assert property (
    $past(rstn) |-> select_or_active_pin_oe_n == !$past(act_drv))
    else $error("active pin enable wrong");
  chk_active_pin_level: assert property (
    $past(rstn) && $past(act_drv) |-> select_or_active_pin_out ==
    $past(pol_r[3] ~^ clk1_active_status))
    else $error("active pin level wrong");
  chk_select_from_regs: assert property (
    $past(rstn) && $past(!auto_select_mode && !sel_r[0]) |->
    active_clock_select == $past(clock_select_bits))
    else $error("register clock choice wrong");
  cover property (irq_status && !irq_or_clk1_fault_out_oe_n);
  cover property (!select_or_active_pin_oe_n);
  cover property (!auto_select_mode && sel_r == 2'h3);
endmodule
bind alarm_pin_and_interrupt_mask alarm_pin_props i_props (.*);

// *** board_model.sv ***
/*
  Board side of the select/active pin: resolves the wire level.
  Assumes the bench drives only while the device has released the pin.
*/
`timescale 1ns/10ps
module board_model
(
  input wire ref_clk,
  input wire dev_out,
  input wire dev_oe_n,
  input wire drv_en,
  input wire drv_val,
  output logic pin_level
);
  logic last_r = 1'b0;
  // no pull on this wire, so a floating pin reads the inverse of the
  // last driven level and holds it until someone drives again
  always_comb
    pin_level = !dev_oe_n ? dev_out : drv_en ? drv_val : ~last_r;
  always @(posedge ref_clk)
    if (!dev_oe_n || drv_en)
      last_r <= pin_level;
endmodule

// *** testbench.sv ***
/*
  Self-checking bench for the alarm pin block: register access,
  pin routing, polarity, masking and clock choice.
  Assumes a 10 MHz ref_clk and the board model on the select pin.
*/
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic clk1_fault_status = 0, clk2_fault_status = 0;
  logic lock_loss_irq_status = 0, clk1_active_status = 0;
  logic auto_select_mode = 0, drv_en = 0, drv_val = 0;
  logic [5:0] fl = 0, m;
  logic [2:0] freq_lock_masks = 0;
  logic [1:0] clock_select_bits = 0;
  wire [7:0] reg_rdata;
  wire [1:0] active_clock_select;
  wire reg_hit, select_or_active_pin_in, select_or_active_pin_out;
  wire select_or_active_pin_oe_n, clk2_fault_out, clk2_fault_out_oe_n;
  wire irq_or_clk1_fault_out, irq_or_clk1_fault_out_oe_n;
  wire lock_loss_out, lock_loss_out_oe_n, irq_status;
  int num_errors = 0, samples_checked = 0, cycles = 0, i, k, p;
  logic [7:0] rv [5] = '{8'h3e, 8'hff, 8'hdf, 8'h1f, 8'h00};
  logic [7:0] rz [4] = '{8'h30, 8'hfc, 8'hd0, 8'h18};
  alarm_pin_and_interrupt_mask i_alarm_pin_and_interrupt_mask (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_hit, .clk1_fault_status, .clk2_fault_status,
    .lock_loss_irq_status, .clk1_active_status,
    .ref_sigloss_flag(fl[0]), .clk1_sigloss_flag(fl[1]),
    .clk2_sigloss_flag(fl[2]), .lock_loss_flag(fl[3]),
    .clk1_freq_offset_flag(fl[4]), .clk2_freq_offset_flag(fl[5]),
    .freq_lock_masks, .auto_select_mode, .clock_select_bits,
    .select_or_active_pin_in, .select_or_active_pin_out,
    .select_or_active_pin_oe_n, .clk2_fault_out, .clk2_fault_out_oe_n,
    .irq_or_clk1_fault_out, .irq_or_clk1_fault_out_oe_n,
    .lock_loss_out, .lock_loss_out_oe_n, .irq_status,
    .active_clock_select);
  board_model i_board_model (.ref_clk, .dev_out(select_or_active_pin_out),
    .dev_oe_n(select_or_active_pin_oe_n), .drv_en, .drv_val,
    .pin_level(select_or_active_pin_in));
  initial forever #50 ref_clk = ~ref_clk;
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // output level is ignored while the pin is released
  task pk(input logic oe, o, eoe, eo);
    chk({6'h0, oe, oe | o}, {6'h0, eoe, eoe | eo});
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, e, input logic h);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk);
    reg_rd = 0;
    chk(reg_rdata, e);
    chk({7'h0, reg_hit}, {7'h0, h});
  endtask
  task settle;
    repeat (4) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rstn = 1;
    for (i = 0; i < 5; i++)
      rd(8'h14 + i, rv[i], i < 4);
    pk(clk2_fault_out_oe_n, clk2_fault_out, 0, 0);
    pk(irq_or_clk1_fault_out_oe_n, irq_or_clk1_fault_out, 0, 0);
    pk(lock_loss_out_oe_n, lock_loss_out, 0, 0);
    pk(select_or_active_pin_oe_n, 0, 1, 0);
    wr(8'h18, 8'hff);
    rd(8'h14, 8'h3e, 1);
    for (i = 0; i < 4; i++)
    begin
      wr(8'h14 + i, 8'h00);
      rd(8'h14 + i, rz[i], 1);
    end
    settle;
    pk(clk2_fault_out_oe_n, 0, 1, 0);
    pk(irq_or_clk1_fault_out_oe_n, 0, 1, 0);
    pk(lock_loss_out_oe_n, 0, 1, 0);
    pk(select_or_active_pin_oe_n, 0, 1, 0);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h3f, 1);
    wr(8'h14, 8'h0e);
    for (p = 0; p < 2; p++)
    begin
      wr(8'h16, {4'h0, {4{p[0]}}});
      clk2_fault_status = 1;
      clk1_fault_status = p[0];
      lock_loss_irq_status = !p[0];
      settle;
      pk(clk2_fault_out_oe_n, clk2_fault_out, 0, p[0]);
      pk(irq_or_clk1_fault_out_oe_n, irq_or_clk1_fault_out, 0, 1);
      pk(lock_loss_out_oe_n, lock_loss_out, 0, 0);
    end
    wr(8'h14, 8'h0f);
    wr(8'h16, 8'h01);
    for (i = 0; i < 6; i++)
      for (k = 0; k < 2; k++)
      begin
        fl = 6'h01 << i;
        m = k ? fl : ~fl;
        wr(8'h17, {5'h00, m[2:0]});
        freq_lock_masks = m[5:3];
        settle;
        chk({7'h0, irq_status}, {7'h0, !k});
        pk(irq_or_clk1_fault_out_oe_n, irq_or_clk1_fault_out, 0, !k);
        rd(8'h17, 8'h18 | m[2:0], 1);
      end
    wr(8'h16, 8'h00);
    settle;
    pk(irq_or_clk1_fault_out_oe_n, irq_or_clk1_fault_out, 0, 1);
    wr(8'h15, 8'h02);
    wr(8'h16, 8'h08);
    for (i = 0; i < 4; i++)
    begin
      clock_select_bits = i[1:0];
      clk1_active_status = i[0];
      settle;
      chk({6'h0, active_clock_select}, {6'h0, i[1:0]});
      pk(select_or_active_pin_oe_n, select_or_active_pin_out, 0, i[0]);
    end
    wr(8'h16, 8'h00);
    settle;
    pk(select_or_active_pin_oe_n, select_or_active_pin_out, 0, 0);
    wr(8'h15, 8'h03);
    settle;
    drv_en = 1;
    for (i = 0; i < 2; i++)
    begin
      drv_val = i[0];
      settle;
      chk({6'h0, active_clock_select}, i[7:0]);
      pk(select_or_active_pin_oe_n, 0, 1, 0);
    end
    drv_en = 0;
    auto_select_mode = 1;
    settle;
    pk(select_or_active_pin_oe_n, select_or_active_pin_out, 0, 0);
    report_and_stop;
  end
endmodule
